/* core/ppt_defines.svh */
// Register indices, field positions, reset values and counts of the pattern tester
`ifndef PPT_DEFINES_SVH
`define PPT_DEFINES_SVH

// Register indices; byte address is four times the index
`define PPT_IDX_CTRL 8'h71
`define PPT_IDX_STAT 8'h72
`define PPT_IDX_IND  8'h73
`define PPT_IDX_CFG  8'hC7
`define PPT_IDX_NONE 8'hFF

// pattern_control fields
`define PPT_F_EINS   0
`define PPT_F_RECEIVE_INVERT   1
`define PPT_F_TRANSMIT_INVERT   2
`define PPT_F_SEQ_LO 4
`define PPT_F_SEQ_HI 5

// pattern_status_and_irq_enable fields
`define PPT_F_SYNC 0
`define PPT_F_BIT_ERROR_IRQ_ENABLE 1
`define PPT_F_SYNE 2

// pattern_irq_indication fields
`define PPT_F_BIT_ERROR_INDICATION 0
`define PPT_F_SYNI 1

// payload_test_configuration fields
`define PPT_F_TEN     0
`define PPT_F_MODE_LO 1
`define PPT_F_MODE_HI 2
`define PPT_F_DIR     3

// Reset values and counts
`define PPT_RST_BYTE  8'h00
`define PPT_SEED      20'hFFFFF
`define PPT_SYNC_HITS 6'h20
`define PPT_WIN_LAST  6'h2F
`define PPT_ERR_LIMIT 4'hA
`define PPT_LSB_IDX   3'h7

`endif

/* core/ppt_pkg.sv */
// Types and the sequence feedback function of the pattern tester
package ppt_pkg;

    typedef enum logic [1:0] {SEQ_11, SEQ_15, SEQ_20, SEQ_RSV} ppt_seq_e;
    typedef enum logic [1:0] {MODE_UNF, MODE_8, MODE_7, MODE_RSV} ppt_mode_e;
    typedef enum logic [1:0] {CHK_IDLE, CHK_HUNT, CHK_SYNC} ppt_chk_e;

    // Feedback of the selected sequence; reserved code runs the short one
    function automatic logic ppt_fb(ppt_seq_e s, logic [19:0] r);
        case (s)
            SEQ_15:  ppt_fb = r[14] ^ r[13];
            SEQ_20:  ppt_fb = r[19] ^ r[16];
            default: ppt_fb = r[10] ^ r[8];
        endcase
    endfunction

endpackage

/* core/ppt_pat_if.sv */
// Signals shared by the tester core, its generator and its checker
interface ppt_pat_if;
    import ppt_pkg::*;
    ppt_seq_e seq;
    logic     run;
    logic     g_step;
    logic     g_bit;
    logic     c_step;
    logic     c_bit;
    logic     c_err;
    logic     c_sync;
    modport ctl (output seq, run, g_step, c_step, c_bit, input g_bit, c_err, c_sync);
    modport gen (input seq, run, g_step, output g_bit);
    modport chk (input seq, run, c_step, c_bit, output c_err, c_sync);
endinterface

/* core/ppt_gen.sv */
// Pattern generator shift register
`include "ppt_defines.svh"
module ppt_gen (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Core side
    ppt_pat_if.gen   p
);
    import ppt_pkg::*;

    logic [19:0] sh_r;
    logic        fb;

    assign fb = ppt_fb(p.seq, sh_r);
    assign p.g_bit = fb;

    // Reseeded whenever the test is off, so each start gives the same stream
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sh_r <= `PPT_SEED;
        end else if (!p.run) begin
            sh_r <= `PPT_SEED;
        end else if (p.g_step) begin
            sh_r <= {sh_r[18:0], fb};
        end
    end
endmodule

/* core/ppt_chk.sv */
// Pattern checker: self-synchronising predictor with sync and loss of sync
`include "ppt_defines.svh"
module ppt_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Core side
    ppt_pat_if.chk   p
);
    import ppt_pkg::*;

    ppt_chk_e    st_r;
    ppt_chk_e    st_nxt;
    logic [19:0] hist_r;
    logic [5:0]  hits_r;
    logic [5:0]  win_r;
    logic [3:0]  errs_r;
    logic        miss;
    logic        lose;
    logic        gain;

    // Prediction from received history, so no seed alignment is needed
    assign miss = p.c_step & (p.c_bit ^ ppt_fb(p.seq, hist_r));
    assign gain = p.c_step & !miss & (hits_r == `PPT_SYNC_HITS - 6'h01);
    assign lose = miss & (errs_r >= `PPT_ERR_LIMIT);
    assign p.c_err = (st_r == CHK_SYNC) & miss;
    assign p.c_sync = (st_r == CHK_SYNC);

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            CHK_IDLE: st_nxt = p.run ? CHK_HUNT : CHK_IDLE;
            CHK_HUNT: st_nxt = !p.run ? CHK_IDLE : (gain ? CHK_SYNC : CHK_HUNT);
            CHK_SYNC: st_nxt = !p.run ? CHK_IDLE : (lose ? CHK_HUNT : CHK_SYNC);
            default:  st_nxt = CHK_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r   <= CHK_IDLE;
            hist_r <= 20'h00000;
        end else begin
            st_r <= st_nxt;
            if (p.c_step) begin
                hist_r <= {hist_r[18:0], p.c_bit};
            end
        end
    end

    // Match run while hunting; fixed window and error count while in sync
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hits_r <= 6'h00;
            win_r  <= 6'h00;
            errs_r <= 4'h0;
        end else if (st_r != CHK_SYNC || st_nxt != CHK_SYNC) begin
            hits_r <= (st_r == CHK_HUNT && p.c_step && !miss) ? hits_r + 6'h01
                    : ((st_r == CHK_HUNT && !p.c_step) ? hits_r : 6'h00);
            win_r  <= 6'h00;
            errs_r <= 4'h0;
        end else if (p.c_step) begin
            win_r  <= (win_r == `PPT_WIN_LAST) ? 6'h00 : win_r + 6'h01;
            errs_r <= (win_r == `PPT_WIN_LAST) ? 4'h0 : errs_r + {3'h0, miss};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_lose;
        (st_r == CHK_SYNC && p.run && miss && errs_r == `PPT_ERR_LIMIT) |=> st_r == CHK_HUNT;
    endproperty
    a_lose: assert property (p_lose) else $error("sync not lost on eleventh error");

    property p_gain;
        (st_r == CHK_HUNT && p.run && gain) |=> st_r == CHK_SYNC;
    endproperty
    a_gain: assert property (p_gain) else $error("sync not declared on match run");
endmodule

/* core/ppt_top.sv */
// Pattern tester core: AHB-Lite registers, slot insertion and extraction
// What this block does
// - Inject pattern in one path, check opposite path, per direction bit.
// - Two-bit framing mode: unframed, 8-bit slots or 7-bit slots.
// - Unframed: every bit used for test, slot selection ignored.
// - Slot modes: only slots with their test bit set are used.
// - 7-bit mode: only upper seven bits of a slot used, last untouched.
// - Sequence select picks 2^11-1, 2^15-1 or 2^20-1 sequence.
// - Generation starts on a 0 to 1 edge of test enable.
// - Writing 1 to error insert flips exactly one generated bit.
// - Transmit invert applies before the single error is inserted.
// - Checker starts extracting on a 0 to 1 edge of test enable.
// - Checker predicts sequence from extracted bits; matches declare sync.
// - In sync each mismatch latches bit error flag and pulses counters.
// - Bit error flag with its enable asserts the interrupt.
// - More than 10 errors in a fixed 48-bit window loses sync.
// - Any sync state change sets the sync change flag.
// - Sync change flag with its enable asserts the interrupt.
// - Receive invert flips extracted bits before comparison.
// - Interrupt output is driven low while an enabled source pends.
//
// Implementation choice: the AHB-Lite interface to the registers.
`include "ppt_defines.svh"
module ppt_top (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // AHB-Lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic [31:0]      HRDATA,
    // Transmit payload path
    input  wire logic        TX_DIN,
    input  wire logic        TX_STB,
    input  wire logic        TX_SLOT_TEST,
    input  wire logic [2:0]  TX_BIT_IDX,
    output logic             TX_DOUT,
    output logic             TX_OSTB,
    // Receive payload path
    input  wire logic        RX_DIN,
    input  wire logic        RX_STB,
    input  wire logic        RX_SLOT_TEST,
    input  wire logic [2:0]  RX_BIT_IDX,
    output logic             RX_DOUT,
    output logic             RX_OSTB,
    // Status
    output logic             PMON_BIT_ERR,
    output logic             INT_N
);
    import ppt_pkg::*;

    ppt_pat_if pat ();

    // Register state
    logic       transmit_invert_r;
    logic       receive_invert_r;
    logic       eins_r;
    ppt_seq_e   seq_r;
    logic       bit_error_irq_enable_r;
    logic       sync_change_irq_enable_r;
    logic       bit_error_indication_r;
    logic       sync_change_indication_r;
    logic       ten_r;
    ppt_mode_e  mode_r;
    logic       dir_r;
    logic       run_r;
    logic       ten_d_r;
    logic       sync_d_r;

    // Bus state
    logic       dwr_r;
    logic [7:0] didx_r;
    logic [7:0] rd_r;

    // Outputs
    logic       tx_dout_r;
    logic       tx_ostb_r;
    logic       rx_dout_r;
    logic       rx_ostb_r;
    logic       pmon_r;
    logic       int_n_r;

    // Decode wires
    logic       ap_ok;
    logic [7:0] ap_idx;
    logic [7:0] ctrl_rd;
    logic [7:0] stat_rd;
    logic [7:0] ind_rd;
    logic [7:0] cfg_rd;
    logic [7:0] rd_val;
    logic       wr_ctrl;
    logic       wr_stat;
    logic       wr_ind;
    logic       wr_cfg;
    logic       eins_wr;
    logic       clr_bit_error_indication;
    logic       clr_sync_change_indication;
    logic       tx_hit;
    logic       rx_hit;
    logic       pat_bit;
    logic       irq;

    // Slot selection, shared by both paths
    function automatic logic slot_hit(ppt_mode_e m, logic test, logic [2:0] idx);
        case (m)
            MODE_8:  slot_hit = test;
            MODE_7:  slot_hit = test & (idx != `PPT_LSB_IDX);
            default: slot_hit = 1'b1;
        endcase
    endfunction

    // Address phase; anything above the register window is unmapped
    assign ap_ok  = HSEL & HREADY & HTRANS[1];
    assign ap_idx = (HADDR[31:10] == 22'h0) ? HADDR[9:2] : `PPT_IDX_NONE;

    assign ctrl_rd = {2'h0, seq_r, 1'b0, transmit_invert_r, receive_invert_r, eins_r};
    assign stat_rd = {5'h00, sync_change_irq_enable_r, bit_error_irq_enable_r, pat.c_sync};
    assign ind_rd  = {6'h00, sync_change_indication_r, bit_error_indication_r};
    assign cfg_rd  = {4'h0, dir_r, mode_r, ten_r};
    assign rd_val  = (ap_idx == `PPT_IDX_CTRL) ? ctrl_rd
                   : (ap_idx == `PPT_IDX_STAT) ? stat_rd
                   : (ap_idx == `PPT_IDX_IND)  ? ind_rd
                   : (ap_idx == `PPT_IDX_CFG)  ? cfg_rd
                   : 8'h00;

    // Data phase write strobes
    assign wr_ctrl   = dwr_r & (didx_r == `PPT_IDX_CTRL);
    assign wr_stat   = dwr_r & (didx_r == `PPT_IDX_STAT);
    assign wr_ind    = dwr_r & (didx_r == `PPT_IDX_IND);
    assign wr_cfg    = dwr_r & (didx_r == `PPT_IDX_CFG);
    assign eins_wr   = wr_ctrl & HWDATA[`PPT_F_EINS];
    assign clr_bit_error_indication  = wr_ind & HWDATA[`PPT_F_BIT_ERROR_INDICATION];
    assign clr_sync_change_indication = wr_ind & HWDATA[`PPT_F_SYNI];

    // Zero wait states, never an error
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign HRDATA    = {24'h000000, rd_r};

    // Path steering
    assign tx_hit  = TX_STB & run_r & slot_hit(mode_r, TX_SLOT_TEST, TX_BIT_IDX);
    assign rx_hit  = RX_STB & run_r & slot_hit(mode_r, RX_SLOT_TEST, RX_BIT_IDX);
    assign pat_bit = pat.g_bit ^ transmit_invert_r ^ eins_r;

    assign pat.seq    = seq_r;
    assign pat.run    = run_r;
    assign pat.g_step = dir_r ? rx_hit : tx_hit;
    assign pat.c_step = dir_r ? tx_hit : rx_hit;
    assign pat.c_bit  = (dir_r ? TX_DIN : RX_DIN) ^ receive_invert_r;

    assign irq = (bit_error_indication_r & bit_error_irq_enable_r) | (sync_change_indication_r & sync_change_irq_enable_r);

    assign TX_DOUT      = tx_dout_r;
    assign TX_OSTB      = tx_ostb_r;
    assign RX_DOUT      = rx_dout_r;
    assign RX_OSTB      = rx_ostb_r;
    assign PMON_BIT_ERR = pmon_r;
    assign INT_N        = int_n_r;

    ppt_gen u_gen (
        .clk (CLK),
        .rst (RST),
        .p   (pat.gen)
    );

    ppt_chk u_chk (
        .clk (CLK),
        .rst (RST),
        .p   (pat.chk)
    );

    // Reads are sampled in the address phase; the master never overlaps phases
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            dwr_r  <= 1'b0;
            didx_r <= `PPT_IDX_NONE;
            rd_r   <= `PPT_RST_BYTE;
        end else begin
            dwr_r  <= ap_ok & HWRITE;
            didx_r <= ap_ok ? ap_idx : `PPT_IDX_NONE;
            rd_r   <= (ap_ok & !HWRITE) ? rd_val : rd_r;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            transmit_invert_r <= 1'b0;
            receive_invert_r <= 1'b0;
            seq_r  <= SEQ_11;
        end else if (wr_ctrl) begin
            transmit_invert_r <= HWDATA[`PPT_F_TRANSMIT_INVERT];
            receive_invert_r <= HWDATA[`PPT_F_RECEIVE_INVERT];
            seq_r  <= ppt_seq_e'(HWDATA[`PPT_F_SEQ_HI:`PPT_F_SEQ_LO]);
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bit_error_irq_enable_r  <= 1'b0;
            sync_change_irq_enable_r <= 1'b0;
        end else if (wr_stat) begin
            bit_error_irq_enable_r  <= HWDATA[`PPT_F_BIT_ERROR_IRQ_ENABLE];
            sync_change_irq_enable_r <= HWDATA[`PPT_F_SYNE];
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ten_r  <= 1'b0;
            mode_r <= MODE_UNF;
            dir_r  <= 1'b0;
        end else if (wr_cfg) begin
            ten_r  <= HWDATA[`PPT_F_TEN];
            mode_r <= ppt_mode_e'(HWDATA[`PPT_F_MODE_HI:`PPT_F_MODE_LO]);
            dir_r  <= HWDATA[`PPT_F_DIR];
        end
    end

    // Test runs only after a rising edge of the enable, and stops with it
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ten_d_r <= 1'b0;
            run_r   <= 1'b0;
        end else begin
            ten_d_r <= ten_r;
            run_r   <= ten_r & (run_r | !ten_d_r);
        end
    end

    // One pending inversion, used up by the next generated bit; a new write wins
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            eins_r <= 1'b0;
        end else begin
            eins_r <= eins_wr | (eins_r & !pat.g_step);
        end
    end

    // Sticky flags; a set in the clearing cycle wins
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sync_d_r <= 1'b0;
            bit_error_indication_r   <= 1'b0;
            sync_change_indication_r  <= 1'b0;
        end else begin
            sync_d_r <= pat.c_sync;
            bit_error_indication_r   <= pat.c_err | (bit_error_indication_r & !clr_bit_error_indication);
            sync_change_indication_r  <= (pat.c_sync ^ sync_d_r) | (sync_change_indication_r & !clr_sync_change_indication);
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pmon_r  <= 1'b0;
            int_n_r <= 1'b1;
        end else begin
            pmon_r  <= pat.c_err;
            int_n_r <= !irq;
        end
    end

    // Unselected bits pass unchanged with the same one-cycle delay
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tx_dout_r <= 1'b0;
            tx_ostb_r <= 1'b0;
            rx_dout_r <= 1'b0;
            rx_ostb_r <= 1'b0;
        end else begin
            tx_dout_r <= (tx_hit & !dir_r) ? pat_bit : TX_DIN;
            tx_ostb_r <= TX_STB;
            rx_dout_r <= (rx_hit & dir_r) ? pat_bit : RX_DIN;
            rx_ostb_r <= RX_STB;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    property p_inject_tx;
        (tx_hit && !dir_r && !eins_r) |=> TX_DOUT == ($past(pat.g_bit) ^ $past(transmit_invert_r));
    endproperty
    a_inject_tx: assert property (p_inject_tx) else $error("tx bit not from pattern");

    property p_check_tx;
        (dir_r && run_r && mode_r == MODE_UNF) |-> pat.c_step == TX_STB && pat.g_step == RX_STB;
    endproperty
    a_check_tx: assert property (p_check_tx) else $error("direction steering wrong");

    property p_pass_tx;
        (TX_STB && !(tx_hit && !dir_r)) |=> TX_DOUT == $past(TX_DIN) && TX_OSTB;
    endproperty
    a_pass_tx: assert property (p_pass_tx) else $error("unselected tx bit altered");

    property p_lsb_free;
        (mode_r == MODE_7 && RX_STB && RX_BIT_IDX == `PPT_LSB_IDX) |=> RX_DOUT == $past(RX_DIN);
    endproperty
    a_lsb_free: assert property (p_lsb_free) else $error("slot lsb touched in 7-bit mode");

    property p_unframed;
        (mode_r == MODE_UNF && run_r && TX_STB && !TX_SLOT_TEST && !dir_r) |-> pat.g_step;
    endproperty
    a_unframed: assert property (p_unframed) else $error("unframed bit not used");

    property p_start;
        (ten_r && !ten_d_r) |=> run_r;
    endproperty
    a_start: assert property (p_start) else $error("test did not start on enable edge");

    property p_no_start;
        (ten_r && ten_d_r) |=> run_r == $past(run_r);
    endproperty
    a_no_start: assert property (p_no_start) else $error("held enable restarted test");

    property p_eins_once;
        (eins_r && pat.g_step && !eins_wr) |=> !eins_r;
    endproperty
    a_eins_once: assert property (p_eins_once) else $error("error insert not single");

    property p_bit_error_indication;
        pat.c_err |=> bit_error_indication_r && PMON_BIT_ERR ##1 !PMON_BIT_ERR || $past(pat.c_err);
    endproperty
    a_bit_error_indication: assert property (p_bit_error_indication) else $error("bit error not latched");

    property p_sync_chg;
        (pat.c_sync != sync_d_r) |=> sync_change_indication_r;
    endproperty
    a_sync_chg: assert property (p_sync_chg) else $error("sync change not flagged");

    property p_int_ber;
        (bit_error_indication_r && bit_error_irq_enable_r) |=> !INT_N;
    endproperty
    a_int_ber: assert property (p_int_ber) else $error("bit error irq missing");

    property p_int_sync;
        (sync_change_indication_r && sync_change_irq_enable_r) |=> !INT_N;
    endproperty
    a_int_sync: assert property (p_int_sync) else $error("sync change irq missing");

    property p_int_idle;
        !irq |=> INT_N;
    endproperty
    a_int_idle: assert property (p_int_idle) else $error("irq without enabled source");

    property p_hold;
        (bit_error_indication_r && !clr_bit_error_indication) |=> bit_error_indication_r;
    endproperty
    a_hold: assert property (p_hold) else $error("bit error flag dropped");

    c_sync_up: cover property (!pat.c_sync ##1 pat.c_sync);
    c_sync_down: cover property (pat.c_sync ##1 !pat.c_sync);
    c_inserted: cover property (eins_r && pat.g_step);
    c_mode7: cover property (mode_r == MODE_7 && tx_hit);
endmodule

/* dv/ppt_path_model.sv */
// Far-side payload datapath model: a strobe every cycle, 8-bit slots, optional loopback
module ppt_path_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Test control
    input  wire logic       loop_en,
    input  wire logic [3:0] slot_mask,
    // Design side
    input  wire logic       tx_dout,
    output logic            stb,
    output logic            slot_test,
    output logic [2:0]      bit_idx,
    output logic            tx_din,
    output logic            rx_din,
    // Slot position of the bit now on the outputs
    output logic [2:0]      a_idx,
    output logic            a_test
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] cnt_r;
    // Idle filler is all ones, which none of the sequences keeps up for long
    assign tx_din    = 1'b1;
    assign bit_idx   = cnt_r[2:0];
    assign slot_test = slot_mask[cnt_r[4:3]];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r  <= 5'h00;
            stb    <= 1'b0;
            rx_din <= 1'b1;
            a_idx  <= 3'h0;
            a_test <= 1'b0;
        end else begin
            cnt_r  <= cnt_r + 5'h01;
            stb    <= 1'b1;
            rx_din <= loop_en ? tx_dout : 1'b1;
            a_idx  <= bit_idx;
            a_test <= slot_test;
        end
    end
endmodule

/* dv/tb_top.sv */
// Self-checking bench of the pattern tester: register tasks, stream monitor, sync runs
`include "ppt_defines.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, hsel, hwrite, hready, loop_en, stb, stest, txd, rxd;
    logic        txo, txs, rxo, rxs, pmon, int_n, a_test, mon_on, sel, pb, hresp;
    logic [1:0]  htrans;
    logic [2:0]  bidx, a_idx;
    logic [3:0]  mask;
    logic [7:0]  ctrl, cfg;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [63:0] hist;
    int          fails, checks_done, nsel, pm_cnt, t1, t2, n;
    logic [7:0] dut_idx [5] = '{`PPT_IDX_CTRL, `PPT_IDX_STAT, `PPT_IDX_IND, `PPT_IDX_CFG,
                                `PPT_IDX_NONE};

    ppt_top dut (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
        .HREADYOUT(hready), .HRESP(hresp), .HRDATA(hrdata), .TX_DIN(txd), .TX_STB(stb),
        .TX_SLOT_TEST(stest), .TX_BIT_IDX(bidx), .TX_DOUT(txo), .TX_OSTB(txs),
        .RX_DIN(rxd), .RX_STB(stb), .RX_SLOT_TEST(stest), .RX_BIT_IDX(bidx),
        .RX_DOUT(rxo), .RX_OSTB(rxs), .PMON_BIT_ERR(pmon), .INT_N(int_n));

    ppt_path_model pm (.clk(clk), .rst(rst), .loop_en(loop_en), .slot_mask(mask),
        .tx_dout(txo), .stb(stb), .slot_test(stest), .bit_idx(bidx), .tx_din(txd),
        .rx_din(rxd), .a_idx(a_idx), .a_test(a_test));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic wait_rdy();
        int i;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (hready !== 1'b1 && i < 50);
        if (i >= 50) begin
            fails++;
            print_verdict();
        end
    endtask

    // Single AHB-Lite word transfer; read data lands in rd
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= {24'h0, d};
        wait_rdy();
        rd = hrdata;
        chk("bus response", {31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    task automatic rdc(input string what, input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(what, rd, {24'h0, exp});
    endtask

    // Polls the sync bit; a poll limit that runs out ends the run
    task automatic wait_stat(input logic s);
        int i;
        i = 0;
        do begin
            bus(1'b0, `PPT_IDX_STAT, 8'h00);
            i++;
        end while (rd[0] !== s && i < 100);
        chk("sync state", {31'h0, rd[0]}, {31'h0, s});
        if (i >= 100) print_verdict();
    endtask

    // Selected bits must follow the recurrence of the chosen sequence, others pass as ones
    always @(negedge clk) begin
        if (pmon === 1'b1) pm_cnt++;
        if (mon_on) begin
            chk("output strobes", {30'h0, txs, rxs}, 32'h3);
            sel = cfg[2:1] != 2'h1 && cfg[2:1] != 2'h2;
            sel = sel || (a_test && !(cfg[2:1] == 2'h2 && a_idx == 3'h7));
            pb = cfg[3] ? rxo : txo;
            chk("checked path untouched", cfg[3] ? txo : rxo, 1);
            if (sel) begin
                if (nsel > 20) chk("pattern bit", pb, hist[t1-1] ^ hist[t2-1] ^ ctrl[2]);
                hist = {hist[62:0], pb};
                nsel++;
            end else begin
                chk("unselected bit", pb, 1);
            end
        end
    end

    task automatic run_cfg(input logic [7:0] c, input logic [7:0] f, input logic [3:0] m);
        ctrl = c;
        cfg  = f;
        mask <= m;
        case (c[5:4])
            2'h1: begin t1 = 15; t2 = 14; end
            2'h2: begin t1 = 20; t2 = 17; end
            default: begin t1 = 11; t2 = 9; end
        endcase
        wr(`PPT_IDX_CTRL, c);
        wr(`PPT_IDX_CFG, f);
        wr(`PPT_IDX_CFG, f | 8'h01);
        tick(4);
        nsel   = 0;
        mon_on = 1'b1;
        tick(100);
        // A held enable must not reseed the stream the monitor is following
        wr(`PPT_IDX_CFG, f | 8'h01);
        tick(100);
        mon_on = 1'b0;
        wr(`PPT_IDX_CFG, f);
    endtask

    initial begin
        rst = 1'b1;
        {hsel, htrans, hwrite, haddr, hwdata, loop_en, mask, mon_on} = '0;
        {fails, checks_done, pm_cnt, ctrl, cfg} = '0;
        hist = '1;
        tick(16);
        rst <= 1'b0;
        tick(1);
        foreach (dut_idx[i]) rdc("reset value", dut_idx[i], 8'h00);
        wr(`PPT_IDX_STAT, 8'h07);
        rdc("status read-only bit", `PPT_IDX_STAT, 8'h06);
        for (n = 0; n < 4; n++) run_cfg(8'(n << 4), 8'h00, 4'h0);
        run_cfg(8'h10, 8'h02, 4'h5);
        run_cfg(8'h20, 8'h04, 4'hF);
        run_cfg(8'h00, 8'h06, 4'h0);
        run_cfg(8'h04, 8'h08, 4'h0);
        // Loop the transmit path back so the checker sees its own pattern
        loop_en <= 1'b1;
        wr(`PPT_IDX_CTRL, 8'h20);
        wr(`PPT_IDX_CFG, 8'h01);
        wait_stat(1'b1);
        rdc("sync change flag", `PPT_IDX_IND, 8'h02);
        chk("interrupt on sync change", int_n, 0);
        wr(`PPT_IDX_IND, 8'h02);
        tick(2);
        rdc("flags cleared", `PPT_IDX_IND, 8'h00);
        chk("interrupt released", int_n, 1);
        pm_cnt = 0;
        wr(`PPT_IDX_CTRL, 8'h21);
        tick(60);
        // A self-synchronising predictor sees one flipped bit as data and at both taps
        chk("error pulses", pm_cnt, 3);
        rdc("bit error flag", `PPT_IDX_IND, 8'h01);
        chk("interrupt on bit error", int_n, 0);
        wr(`PPT_IDX_IND, 8'h01);
        rdc("sync kept", `PPT_IDX_STAT, 8'h07);
        wr(`PPT_IDX_CTRL, 8'h22);
        wait_stat(1'b0);
        rdc("loss flags", `PPT_IDX_IND, 8'h03);
        wr(`PPT_IDX_IND, 8'h03);
        wr(`PPT_IDX_CTRL, 8'h26);
        wait_stat(1'b1);
        print_verdict();
    end
endmodule
